// *** hw/gpt_cap_if.sv ***
// Carrier between the timer core and its capture channels.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface gpt_cap_if #(
    parameter int unsigned N = 3
);
    logic [N-1:0] pin;
    logic [31:0] count;
    logic [N-1:0] rise_en;
    logic [N-1:0] fall_en;
    logic [N-1:0] evt;
    logic [N-1:0] rise_seen;
    logic [N-1:0] fall_seen;
    logic [31:0] value [N];
    modport core (output pin, count, rise_en, fall_en, input evt, rise_seen, fall_seen, value);
    modport chan (input pin, count, rise_en, fall_en, output evt, rise_seen, fall_seen, value);
endinterface

// *** hw/gpt_capture.sv ***
// Capture channels: edge detection and snapshot registers.
// Assumes capture pins are synchronous to ref_clk_in.
`timescale 1ns/1ns
module gpt_capture #(
    parameter int unsigned N = 3
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    gpt_cap_if.chan cap
);
    import gpt_pkg::*;
    logic [N-1:0] prev_r;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prev_r <= '0;
        end else begin
            prev_r <= cap.pin;
        end
    end

    always_comb begin
        cap.rise_seen = cap.pin & ~prev_r;
        cap.fall_seen = ~cap.pin & prev_r;
        cap.evt = (cap.rise_seen & cap.rise_en) | (cap.fall_seen & cap.fall_en);
    end

    // ==========================================================
    // Snapshot registers
    for (genvar j = 0; j < N; j++) begin : g_cap
        always_ff @(posedge ref_clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                cap.value[j] <= GPT_RST_WORD;
            end else if (cap.evt[j]) begin
                cap.value[j] <= cap.count;
            end
        end
    end
endmodule

// *** hw/gpt_pkg.sv ***
// Constants, register map and types of the general purpose timer.
// Assumes an APB slave with 32-bit data and byte addresses.
package gpt_pkg;
    // ==========================================================
    // Sizes
    localparam int unsigned GPT_NUM_MATCH = 4;
    localparam int unsigned GPT_NUM_CAP = 3;
    localparam int unsigned GPT_AW = 8;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] GPT_OFS_STATUS = 8'h00;
    localparam logic [7:0] GPT_OFS_MASK = 8'h04;
    localparam logic [7:0] GPT_OFS_CTRL = 8'h08;
    localparam logic [7:0] GPT_OFS_COUNT = 8'h0c;
    localparam logic [7:0] GPT_OFS_PRE_LIMIT = 8'h10;
    localparam logic [7:0] GPT_OFS_PRE_COUNT = 8'h14;
    localparam logic [7:0] GPT_OFS_MATCH_CTL = 8'h18;
    localparam logic [7:0] GPT_OFS_CAP_CTL = 8'h1c;
    localparam logic [7:0] GPT_OFS_OUT_CTL = 8'h20;
    localparam logic [7:0] GPT_OFS_MODE = 8'h24;
    localparam logic [7:0] GPT_OFS_PWM = 8'h28;
    localparam logic [7:0] GPT_OFS_MATCH0 = 8'h2c;
    localparam logic [7:0] GPT_OFS_CAP0 = 8'h40;
    // ==========================================================
    // Field positions
    localparam int unsigned GPT_CTRL_EN_BIT = 0;
    localparam int unsigned GPT_CTRL_HOLD_BIT = 1;
    localparam int unsigned GPT_MCTL_W = 3;
    localparam int unsigned GPT_MCTL_INT = 0;
    localparam int unsigned GPT_MCTL_RST = 1;
    localparam int unsigned GPT_MCTL_STOP = 2;
    localparam int unsigned GPT_CCTL_W = 3;
    localparam int unsigned GPT_CCTL_RISE = 0;
    localparam int unsigned GPT_CCTL_FALL = 1;
    localparam int unsigned GPT_CCTL_INT = 2;
    localparam int unsigned GPT_OCTL_ACT_LSB = 4;
    localparam int unsigned GPT_MODE_CLR_EN_BIT = 4;
    localparam int unsigned GPT_MODE_CLR_SEL_LSB = 5;
    localparam int unsigned GPT_MODE_CLR_FALL_BIT = 7;
    localparam int unsigned GPT_STAT_CAP_LSB = 4;
    // ==========================================================
    // Reset values
    localparam logic [31:0] GPT_RST_WORD = 32'h0000_0000;
    localparam logic [31:0] GPT_RST_MATCH = 32'hffff_ffff;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        GPT_SRC_SYSCLK,
        GPT_SRC_EXT_RISE,
        GPT_SRC_EXT_FALL,
        GPT_SRC_EXT_BOTH
    } gpt_src_t;
    typedef enum logic [1:0] {
        GPT_ACT_NONE,
        GPT_ACT_LOW,
        GPT_ACT_HIGH,
        GPT_ACT_TOGGLE
    } gpt_act_t;
endpackage

// *** hw/gpt_timer.sv ***
// Top of the general purpose timer: APB registers, prescaler, counter,
// match logic, match outputs and interrupt.
// Assumes a zero-wait APB master and pins synchronous to ref_clk_in.
`timescale 1ns/1ns
module gpt_timer #(
    parameter int unsigned NUM_MATCH = 4,
    parameter int unsigned NUM_CAP = 3
) (
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [gpt_pkg::GPT_AW-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic count_clock_in,
    input wire logic [NUM_CAP-1:0] capture_input_in,
    output logic [NUM_MATCH-1:0] match_output_out,
    output logic irq_out
);
    import gpt_pkg::*;

    localparam int unsigned STAT_W = GPT_STAT_CAP_LSB + NUM_CAP;

    // ==========================================================
    // Registers
    logic [STAT_W-1:0] status_r;
    logic [STAT_W-1:0] mask_r;
    logic en_r;
    logic hold_r;
    logic [31:0] tc_r;
    logic [31:0] pr_r;
    logic [31:0] pc_r;
    logic [NUM_MATCH*GPT_MCTL_W-1:0] mctl_r;
    logic [NUM_CAP*GPT_CCTL_W-1:0] cctl_r;
    logic [NUM_MATCH-1:0] out_r;
    logic [NUM_MATCH-1:0] out_nxt;
    logic [2*NUM_MATCH-1:0] act_r;
    logic [7:0] mode_r;
    logic [NUM_MATCH-1:0] pwm_r;
    logic [31:0] mr_sh_r [NUM_MATCH];
    logic [31:0] mr_act_r [NUM_MATCH];
    logic [31:0] prdata_r;
    logic ext_prev_r;

    gpt_cap_if #(.N(NUM_CAP)) cap_bus ();

    gpt_capture #(.N(NUM_CAP)) u_capture (
        .ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .cap(cap_bus)
    );

    // ==========================================================
    // APB decode
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic [GPT_AW-1:0] a;
    logic [31:0] rd_nxt;

    assign a = paddr_in;
    assign wr_en = psel_in && penable_in && pwrite_in && mapped;
    assign rd_setup = psel_in && !penable_in;
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !mapped;

    always_comb begin
        mapped = (a[1:0] == 2'b00) && (a <= GPT_OFS_CAP0 + GPT_AW'(4 * (NUM_CAP - 1)));
        rd_nxt = GPT_RST_WORD;
        unique case (a)
            GPT_OFS_STATUS: rd_nxt = 32'(status_r);
            GPT_OFS_MASK: rd_nxt = 32'(mask_r);
            GPT_OFS_CTRL: rd_nxt = {30'h0, hold_r, en_r};
            GPT_OFS_COUNT: rd_nxt = tc_r;
            GPT_OFS_PRE_LIMIT: rd_nxt = pr_r;
            GPT_OFS_PRE_COUNT: rd_nxt = pc_r;
            GPT_OFS_MATCH_CTL: rd_nxt = 32'(mctl_r);
            GPT_OFS_CAP_CTL: rd_nxt = 32'(cctl_r);
            GPT_OFS_OUT_CTL: rd_nxt = 32'({act_r, out_r});
            GPT_OFS_MODE: rd_nxt = 32'(mode_r);
            GPT_OFS_PWM: rd_nxt = 32'(pwm_r);
            default: begin
                for (int i = 0; i < NUM_MATCH; i++) begin
                    if (a == GPT_OFS_MATCH0 + GPT_AW'(4 * i)) begin
                        rd_nxt = mr_sh_r[i];
                    end
                end
                for (int j = 0; j < NUM_CAP; j++) begin
                    if (a == GPT_OFS_CAP0 + GPT_AW'(4 * j)) begin
                        rd_nxt = cap_bus.value[j];
                    end
                end
            end
        endcase
    end

    // Read data is latched in the setup cycle so it comes from a flip-flop
    // without adding a wait state.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_r <= GPT_RST_WORD;
        end else if (rd_setup) begin
            prdata_r <= rd_nxt;
        end
    end
    assign prdata_out = prdata_r;

    // ==========================================================
    // Count source and prescaler
    logic run;
    logic src_tick;
    logic cnt_tick;
    logic wrap;
    logic ctrl_wr;
    logic tc_wr;
    gpt_src_t src;

    assign src = gpt_src_t'(mode_r[1:0]);
    assign run = en_r && !hold_r;
    assign ctrl_wr = wr_en && (a == GPT_OFS_CTRL);
    assign tc_wr = wr_en && (a == GPT_OFS_COUNT);

    always_comb begin
        unique case (src)
            GPT_SRC_SYSCLK: src_tick = 1'b1;
            GPT_SRC_EXT_RISE: src_tick = count_clock_in && !ext_prev_r;
            GPT_SRC_EXT_FALL: src_tick = !count_clock_in && ext_prev_r;
            GPT_SRC_EXT_BOTH: src_tick = count_clock_in != ext_prev_r;
        endcase
    end

    assign cnt_tick = run && src_tick;
    assign wrap = cnt_tick && (pc_r == pr_r);

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_prev_r <= 1'b0;
        end else begin
            ext_prev_r <= count_clock_in;
        end
    end

    // ==========================================================
    // Match and capture-clear events
    logic [NUM_MATCH-1:0] hit;
    logic [NUM_MATCH-1:0] hit_rst;
    logic [NUM_MATCH-1:0] hit_stop;
    logic any_rst;
    logic any_stop;
    logic cap_clear;
    logic period_start;
    logic [1:0] clr_sel;

    for (genvar i = 0; i < NUM_MATCH; i++) begin : g_match
        assign hit[i] = wrap && (tc_r == mr_act_r[i]);
        assign hit_rst[i] = hit[i] && mctl_r[i*GPT_MCTL_W+GPT_MCTL_RST];
        assign hit_stop[i] = hit[i] && mctl_r[i*GPT_MCTL_W+GPT_MCTL_STOP];
    end
    assign any_rst = |hit_rst;
    assign any_stop = |hit_stop;
    assign period_start = wrap && any_rst;

    assign clr_sel = mode_r[GPT_MODE_CLR_SEL_LSB+:2];
    always_comb begin
        cap_clear = 1'b0;
        if (mode_r[GPT_MODE_CLR_EN_BIT] && 32'(clr_sel) < NUM_CAP) begin
            cap_clear = mode_r[GPT_MODE_CLR_FALL_BIT] ? cap_bus.fall_seen[clr_sel]
                                                      : cap_bus.rise_seen[clr_sel];
        end
    end

    // ==========================================================
    // Counter, prescale counter and control
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tc_r <= GPT_RST_WORD;
        end else if (hold_r || cap_clear) begin
            tc_r <= GPT_RST_WORD;
        end else if (tc_wr) begin
            tc_r <= pwdata_in;
        end else if (wrap) begin
            if (any_rst) begin
                tc_r <= GPT_RST_WORD;
            end else if (!any_stop) begin
                tc_r <= tc_r + 32'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pc_r <= GPT_RST_WORD;
        end else if (hold_r || cap_clear || wrap) begin
            pc_r <= GPT_RST_WORD;
        end else if (cnt_tick) begin
            pc_r <= pc_r + 32'h1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            en_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                hold_r <= pwdata_in[GPT_CTRL_HOLD_BIT];
            end
            if (wrap && any_stop) begin
                en_r <= 1'b0;
            end else if (ctrl_wr) begin
                en_r <= pwdata_in[GPT_CTRL_EN_BIT];
            end
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_r <= '0;
            pr_r <= GPT_RST_WORD;
            mctl_r <= '0;
            cctl_r <= '0;
            act_r <= '0;
            mode_r <= '0;
            pwm_r <= '0;
        end else if (wr_en) begin
            unique case (a)
                GPT_OFS_MASK: mask_r <= pwdata_in[STAT_W-1:0];
                GPT_OFS_PRE_LIMIT: pr_r <= pwdata_in;
                GPT_OFS_MATCH_CTL: mctl_r <= pwdata_in[NUM_MATCH*GPT_MCTL_W-1:0];
                GPT_OFS_CAP_CTL: cctl_r <= pwdata_in[NUM_CAP*GPT_CCTL_W-1:0];
                GPT_OFS_OUT_CTL: act_r <= pwdata_in[GPT_OCTL_ACT_LSB+:2*NUM_MATCH];
                GPT_OFS_MODE: mode_r <= pwdata_in[7:0];
                GPT_OFS_PWM: pwm_r <= pwdata_in[NUM_MATCH-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Match registers with shadows
    // While running, a new value waits in the shadow until the next period
    // starts, so a PWM edge is never moved mid-period.
    for (genvar i = 0; i < NUM_MATCH; i++) begin : g_mr
        always_ff @(posedge ref_clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                mr_sh_r[i] <= GPT_RST_MATCH;
            end else if (wr_en && a == GPT_OFS_MATCH0 + GPT_AW'(4 * i)) begin
                mr_sh_r[i] <= pwdata_in;
            end
        end
        always_ff @(posedge ref_clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                mr_act_r[i] <= GPT_RST_MATCH;
            end else if (period_start || !run) begin
                mr_act_r[i] <= mr_sh_r[i];
            end
        end
    end

    // ==========================================================
    // Match outputs
    for (genvar i = 0; i < NUM_MATCH; i++) begin : g_out
        gpt_act_t act;
        assign act = gpt_act_t'(act_r[2*i+:2]);
        always_comb begin
            out_nxt[i] = out_r[i];
            if (wr_en && a == GPT_OFS_OUT_CTL) begin
                out_nxt[i] = pwdata_in[i];
            end
            if (pwm_r[i]) begin
                if (hit[i]) begin
                    out_nxt[i] = 1'b1;
                end else if (period_start) begin
                    out_nxt[i] = 1'b0;
                end
            end else if (hit[i]) begin
                unique case (act)
                    GPT_ACT_NONE: ;
                    GPT_ACT_LOW: out_nxt[i] = 1'b0;
                    GPT_ACT_HIGH: out_nxt[i] = 1'b1;
                    GPT_ACT_TOGGLE: out_nxt[i] = !out_r[i];
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end
    assign match_output_out = out_r;

    // ==========================================================
    // Captures and interrupt
    assign cap_bus.pin = capture_input_in;
    assign cap_bus.count = tc_r;
    for (genvar j = 0; j < NUM_CAP; j++) begin : g_cctl
        assign cap_bus.rise_en[j] = cctl_r[j*GPT_CCTL_W+GPT_CCTL_RISE];
        assign cap_bus.fall_en[j] = cctl_r[j*GPT_CCTL_W+GPT_CCTL_FALL];
    end

    logic [STAT_W-1:0] stat_set;
    logic [STAT_W-1:0] stat_clr;
    always_comb begin
        stat_set = '0;
        for (int i = 0; i < NUM_MATCH; i++) begin
            stat_set[i] = hit[i] && mctl_r[i*GPT_MCTL_W+GPT_MCTL_INT];
        end
        for (int j = 0; j < NUM_CAP; j++) begin
            stat_set[GPT_STAT_CAP_LSB+j] = cap_bus.evt[j] && cctl_r[j*GPT_CCTL_W+GPT_CCTL_INT];
        end
        stat_clr = (wr_en && a == GPT_OFS_STATUS) ? pwdata_in[STAT_W-1:0] : '0;
    end

    // A new event wins over a clear written in the same cycle.
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~stat_clr) | stat_set;
        end
    end
    assign irq_out = |(status_r & mask_r);

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_cap_clear;
        cap_clear ##1 (tc_r == 32'h0 && pc_r == 32'h0);
    endsequence

    prescale_wrap_a: assert property (wrap && !hold_r && !cap_clear |=> pc_r == 32'h0)
        else $error("prescaler did not restart at its limit");
    count_step_a: assert property (wrap && !any_rst && !any_stop && !cap_clear && !tc_wr && !hold_r
        |=> tc_r == $past(tc_r) + 32'h1)
        else $error("counter did not advance after prescale wrap");
    match_reset_a: assert property (wrap && any_rst && !cap_clear && !tc_wr && !hold_r |=> tc_r == 32'h0)
        else $error("reset on match did not clear counter");
    match_stop_a: assert property (wrap && any_stop && !any_rst && !cap_clear && !tc_wr && !hold_r
        |=> !en_r && tc_r == $past(tc_r) ##1 (tc_r == $past(tc_r) || !$stable(en_r)))
        else $error("stop on match did not halt counter");
    capture_snap_a: assert property (cap_bus.evt[0] |=> cap_bus.value[0] == $past(tc_r))
        else $error("capture register missed the counter value");
    capture_irq_a: assert property (cap_bus.evt[0] && cctl_r[GPT_CCTL_INT]
        |=> status_r[GPT_STAT_CAP_LSB])
        else $error("capture interrupt flag not set");
    capture_clear_a: assert property (cap_clear |-> s_cap_clear)
        else $error("capture clear missed counter or prescaler");
    shadow_hold_a: assert property (run && !period_start |=> mr_act_r[0] == $past(mr_act_r[0]))
        else $error("active match changed mid-period");
    pwm_period_a: assert property (period_start && pwm_r[0] && !hit[0] |=> !match_output_out[0])
        else $error("PWM output not low at period start");
    pwm_edge_a: assert property (hit[0] && pwm_r[0] |=> match_output_out[0])
        else $error("PWM output not high at match");
    timer_mode_a: assert property (run && src == GPT_SRC_SYSCLK && !wrap && !cap_clear
        |=> pc_r == $past(pc_r) + 32'h1)
        else $error("timer mode did not count system clock");
    toggle_out_a: assert property (hit[0] && !pwm_r[0] && act_r[1:0] == 2'b11
        |=> match_output_out[0] != $past(match_output_out[0]))
        else $error("toggle on match did not toggle");
endmodule

// *** sim/gpt_pin_model.sv ***
// Pin-side model of the timer: external count clock and capture pins.
// Assumes the design samples these pins on the rising edge of clk_in.
`timescale 1ns/1ns
module gpt_pin_model (
    input wire logic clk_in,
    input wire logic [3:0] match_in,
    output logic ext_clk_out,
    output logic [2:0] cap_out
);
    // ==========================================================
    // Pin drivers
    // Pins idle low, since the bench starts every capture from a clean level.
    initial begin
        ext_clk_out = 1'b0;
        cap_out = 3'h0;
    end
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clk_in);
            ext_clk_out <= 1'b1;
            repeat (2) @(posedge clk_in);
            ext_clk_out <= 1'b0;
            repeat (2) @(posedge clk_in);
        end
    endtask
    task automatic cap_pulse(input int ch);
        @(posedge clk_in);
        cap_out[ch] <= 1'b1;
        repeat (3) @(posedge clk_in);
        cap_out[ch] <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask
    // Eight cycles let a new match value reach the output before counting starts.
    task automatic count_hi(output int h);
        h = 0;
        repeat (8) @(negedge clk_in);
        repeat (40) begin
            @(negedge clk_in);
            if (match_in[0] === 1'b1) begin
                h++;
            end
        end
    endtask
endmodule

// *** sim/gpt_timer_tb.sv ***
// Self-checking bench of the general purpose timer.
// Assumes the pin model of gpt_pin_model.sv and the design under hw.
`timescale 1ns/1ns
module gpt_timer_tb;
    import gpt_pkg::*;
    logic ref_clk_in, rstn_in, psel, penable, pwrite, pready, pslverr, ext_clk, irq, lvl, eo;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, m, lim;
    logic [2:0] cap;
    logic [3:0] mout;
    logic [32:0] notes[$];
    int err_count, samples_checked, hi;
    gpt_timer DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .count_clock_in(ext_clk), .capture_input_in(cap),
        .match_output_out(mout), .irq_out(irq));
    gpt_pin_model PM (.clk_in(ref_clk_in), .match_in(mout), .ext_clk_out(ext_clk), .cap_out(cap));
    // ==========================================================
    // Bus tasks
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // An idle cycle opens every transfer, so no signal is driven twice in one step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            report_and_stop;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        notes.push_back({e, d});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(negedge ref_clk_in);
            n++;
        end
        if (n >= 2000) begin
            err_count++;
            report_and_stop;
        end
    endtask
    // Read results are compared against the oldest note at the access edge.
    always @(posedge ref_clk_in) begin
        if (psel && penable && pready && !pwrite) begin
            chk({pslverr, prdata}, (notes.size() > 0) ? notes.pop_front() : 33'h1_dead_beef);
        end
    end
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // ==========================================================
    // Scenarios
    initial begin
        rstn_in = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        void'($urandom(57383));
        repeat (6) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        rd(GPT_OFS_MATCH0, GPT_RST_MATCH, 1'b0);
        rd(8'h4c, 32'h0, 1'b1);
        wr(GPT_OFS_MASK, 32'h1f);
        for (int a = 0; a < 4; a++) begin
            m = 32'h2 + ($urandom % 6);
            lim = $urandom % 3;
            lvl = 1'($urandom % 2);
            eo = (a == 0) ? lvl : (a == 3) ? ~lvl : (a == 2);
            wr(GPT_OFS_COUNT, 32'h0);
            wr(GPT_OFS_PRE_LIMIT, lim);
            wr(GPT_OFS_MATCH0, m);
            wr(GPT_OFS_MATCH_CTL, 32'h5);
            wr(GPT_OFS_OUT_CTL, {26'h0, 2'(a), 3'h0, lvl});
            wr(GPT_OFS_CTRL, 32'h1);
            wait_irq;
            rd(GPT_OFS_COUNT, m, 1'b0);
            rd(GPT_OFS_CTRL, 32'h0, 1'b0);
            rd(GPT_OFS_PRE_COUNT, 32'h0, 1'b0);
            rd(GPT_OFS_STATUS, 32'h1, 1'b0);
            chk({29'h0, mout}, {29'h0, 3'h0, eo});
            wr(GPT_OFS_STATUS, 32'h7f);
            @(negedge ref_clk_in);
            chk({32'h0, irq}, 33'h0);
        end
        wr(GPT_OFS_COUNT, 32'h0);
        wr(GPT_OFS_PRE_LIMIT, 32'h0);
        wr(GPT_OFS_MATCH0, 32'h1);
        wr(GPT_OFS_MATCH0 + 8'h0c, 32'h3);
        wr(GPT_OFS_MATCH_CTL, 32'h601);
        wr(GPT_OFS_PWM, 32'h1);
        wr(GPT_OFS_MASK, 32'h0);
        wr(GPT_OFS_CTRL, 32'h1);
        PM.count_hi(hi);
        chk(33'(hi), 33'd20);
        wr(GPT_OFS_MATCH0, 32'h2);
        PM.count_hi(hi);
        chk(33'(hi), 33'd10);
        rd(GPT_OFS_STATUS, 32'h9, 1'b0);
        wr(GPT_OFS_CTRL, 32'h0);
        wr(GPT_OFS_MATCH_CTL, 32'h0);
        wr(GPT_OFS_MATCH0, GPT_RST_MATCH);
        wr(GPT_OFS_MATCH0 + 8'h0c, GPT_RST_MATCH);
        wr(GPT_OFS_CTRL, 32'h1);
        m = 32'h3 + ($urandom % 5);
        for (int s = 3; s > 0; s--) begin
            wr(GPT_OFS_MODE, 32'(s));
            wr(GPT_OFS_COUNT, 32'h0);
            PM.ext_pulses(m);
            rd(GPT_OFS_COUNT, (s == 3) ? 2 * m : m, 1'b0);
        end
        wr(GPT_OFS_CAP_CTL, 32'h85);
        PM.cap_pulse(0);
        PM.cap_pulse(1);
        PM.cap_pulse(2);
        chk({32'h0, irq}, 33'h0);
        wr(GPT_OFS_MASK, 32'h10);
        @(negedge ref_clk_in);
        chk({32'h0, irq}, 33'h1);
        rd(GPT_OFS_CAP0, m, 1'b0);
        rd(GPT_OFS_CAP0 + 8'h04, 32'h0, 1'b0);
        rd(GPT_OFS_CAP0 + 8'h08, m, 1'b0);
        wr(GPT_OFS_MODE, 32'h51);
        PM.cap_pulse(2);
        rd(GPT_OFS_COUNT, 32'h0, 1'b0);
        rd(GPT_OFS_CAP0 + 8'h08, 32'h0, 1'b0);
        report_and_stop;
    end
endmodule
